// >>> hw/pcu_consts.svh
// constants of the privileged call unit: register offsets, fields, resets
`ifndef PCU_CONSTS_SVH
`define PCU_CONSTS_SVH
`define PCU_OFF_CMD      8'h00
`define PCU_OFF_ARG0     8'h04
`define PCU_OFF_ARG1     8'h08
`define PCU_OFF_ARG2     8'h0C
`define PCU_OFF_RESULT   8'h10
`define PCU_OFF_PSTATUS  8'h14
`define PCU_OFF_INITIAL_KERNEL_STACK_PTR     8'h18
`define PCU_OFF_PDB      8'h1C
`define PCU_OFF_ASID     8'h20
`define PCU_OFF_MACHINE_CHECK_ERROR_SUMMARY     8'h24
`define PCU_OFF_EVT_ST   8'h28
`define PCU_OFF_EVT_CLR  8'h2C
`define PCU_OFF_EVT_EN   8'h30
`define PCU_OFF_VEC0     8'h34
`define PCU_OFF_FWBASE   8'h48
`define PCU_PSTAT_MODE   0
`define PCU_PSTAT_INTERRUPT_PRIORITY_LEVEL   8
`define PCU_PAGE_SHIFT   13
`define PCU_NUM_CLASSES  32'h0000_0005
`define PCU_EVT_ILLEGAL  0
`define PCU_EVT_PANIC    1
`define PCU_EVT_DONE     2
`define PCU_EVT_FWJUMP   3
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_MCK     0
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_SCE     1
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_PCE     2
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_DPC     3
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_DSC     4
`define PCU_MACHINE_CHECK_ERROR_SUMMARY_DMK     5
`define PCU_RST_UMODE    1'h0
`define PCU_RST_INTERRUPT_PRIORITY_LEVEL     4'h0
`define PCU_RST_WORD     32'h0000_0000
`endif

// >>> hw/pcu_pkg.sv
// types of the privileged call unit
package pcu_pkg;
	typedef enum logic [1:0] {PCU_IDLE = 2'h0, PCU_EXEC = 2'h1, PCU_WREQ = 2'h3, PCU_WWAIT = 2'h2} pcu_fsm_t;
	typedef enum logic [3:0] {
		PCU_OP_NONE = 4'h0, PCU_OP_SWPIRQL = 4'h1, PCU_OP_SWPKSP = 4'h2, PCU_OP_SWPFW = 4'h3,
		PCU_OP_SWPSPACE = 4'h4, PCU_OP_INVALL = 4'h5, PCU_OP_INVMULT = 4'h6, PCU_OP_INVMULTID = 4'h7,
		PCU_OP_INVONE = 4'h8, PCU_OP_INVONEID = 4'h9, PCU_OP_WRENTRY = 4'hA, PCU_OP_WRERRSUM = 4'hB
	} pcu_op_t;
	typedef enum logic [1:0] {PCU_INV_ALL = 2'h0, PCU_INV_NONGLOBAL = 2'h1, PCU_INV_VA = 2'h2} pcu_inv_kind_t;
	typedef struct packed {
		logic          valid;
		pcu_inv_kind_t kind;
		logic          match_asid;
		logic [7:0]    asid;
		logic [31:0]   va;
	} pcu_inval_t;
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} pcu_rd_t;
	typedef struct packed {
		pcu_fsm_t         fsm;
		pcu_op_t          op;
		logic [31:0]      arg0;
		logic [31:0]      arg1;
		logic [31:0]      arg2;
		logic [31:0]      result;
		logic             umode;
		logic [3:0]       interrupt_priority_level;
		logic [31:0]      initial_kernel_stack_ptr;
		logic [31:0]      pdb;
		logic [7:0]       asid;
		logic [5:0]       machine_check_error_summary;
		logic [3:0]       evt;
		logic [3:0]       evt_en;
		logic             irq;
		logic [4:0][31:0] vec;
		logic [31:0]      fw_base;
		logic             fw_jump;
		logic [31:0]      idx;
		logic [7:0]       walk_asid;
		pcu_inval_t       inval;
		pcu_rd_t          rd;
		logic [15:0]      irq_s1;
		logic [15:0]      irq_s2;
		logic [15:0]      irq_mask;
		logic             irq_pend;
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
	} pcu_state_t;
endpackage

// >>> hw/pcu_top.sv
// privileged call unit: apb registers, call sequencer, invalidation and vector state
`timescale 1ns/10ps
`include "pcu_consts.svh"

module pcu_top (
	// apb clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	// interrupt request pins and their enables
	input  wire logic [15:0]        irq_lines,
	output logic [15:0]             irq_line_enable,
	output logic                    irq_line_pending,
	// machine check event pulses
	input  wire logic               mc_check_evt,
	input  wire logic               sys_corr_evt,
	input  wire logic               proc_corr_evt,
	// array read port for the multiple invalidate walk
	output pcu_pkg::pcu_rd_t        rd,
	input  wire logic               rd_valid,
	input  wire logic [31:0]        rd_data,
	// invalidation and firmware jump
	output pcu_pkg::pcu_inval_t     inval,
	output logic                    fw_jump,
	output logic [31:0]             fw_base,
	// event interrupt
	output logic                    irq
);
	import pcu_pkg::*;

	pcu_state_t s_q;
	pcu_state_t s_d;

	// levels strictly above the current one are enabled
	function automatic logic [15:0] level_mask(input logic [3:0] lvl);
		logic [15:0] m;
		m = '0;
		for (int i = 0; i < 16; i++) begin
			m[i] = (4'(i) > lvl);
		end
		return m;
	endfunction

	logic bus_wr;
	logic bus_rd;
	logic setup;
	logic [31:0] rdata;
	logic        hit;
	assign setup  = psel & ~penable;
	assign bus_wr = psel & penable & s_q.pready & pwrite;
	assign bus_rd = psel & ~penable & ~pwrite;

	// ==========================================================
	// read decode
	always_comb begin
		rdata = `PCU_RST_WORD;
		hit   = 1'b1;
		case (paddr)
			`PCU_OFF_CMD:     rdata = {28'h0, s_q.op};
			`PCU_OFF_ARG0:    rdata = s_q.arg0;
			`PCU_OFF_ARG1:    rdata = s_q.arg1;
			`PCU_OFF_ARG2:    rdata = s_q.arg2;
			`PCU_OFF_RESULT:  rdata = s_q.result;
			`PCU_OFF_PSTATUS: rdata = {20'h0, s_q.interrupt_priority_level, 7'h0, s_q.umode};
			`PCU_OFF_INITIAL_KERNEL_STACK_PTR:    rdata = s_q.initial_kernel_stack_ptr;
			`PCU_OFF_PDB:     rdata = s_q.pdb;
			`PCU_OFF_ASID:    rdata = {24'h0, s_q.asid};
			`PCU_OFF_MACHINE_CHECK_ERROR_SUMMARY:    rdata = {26'h0, s_q.machine_check_error_summary};
			`PCU_OFF_EVT_ST:  rdata = {28'h0, s_q.evt};
			`PCU_OFF_EVT_CLR: rdata = `PCU_RST_WORD;
			`PCU_OFF_EVT_EN:  rdata = {28'h0, s_q.evt_en};
			`PCU_OFF_FWBASE:  rdata = s_q.fw_base;
			default: begin
				if (paddr >= `PCU_OFF_VEC0 && paddr < `PCU_OFF_FWBASE && paddr[1:0] == 2'h0) begin
					rdata = s_q.vec[3'(8'(paddr - `PCU_OFF_VEC0) >> 2)];
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		logic [3:0] ev_set;
		logic [5:0] mc_set;
		logic [5:0] mc_clr;
		logic       busy_wr;
		ev_set  = 4'h0;
		mc_set  = 6'h0;
		mc_clr  = 6'h0;
		busy_wr = 1'b0;
		s_d     = s_q;

		// pin synchroniser, then masked pending
		s_d.irq_s1   = irq_lines;
		s_d.irq_s2   = s_q.irq_s1;
		s_d.irq_mask = level_mask(s_q.interrupt_priority_level);
		s_d.irq_pend = |(s_q.irq_s2 & s_q.irq_mask);

		// single-cycle pulses
		s_d.inval.valid = 1'b0;
		s_d.fw_jump     = 1'b0;

		// apb answer one cycle after setup
		s_d.pready  = setup;
		s_d.prdata  = bus_rd ? rdata : `PCU_RST_WORD;
		s_d.pslverr = setup & ~hit;
		if (setup && pwrite && paddr == `PCU_OFF_CMD && s_q.fsm != PCU_IDLE) begin
			s_d.pslverr = 1'b1;
		end

		// register writes
		if (bus_wr && !s_q.pslverr) begin
			case (paddr)
				`PCU_OFF_CMD: begin
					s_d.op  = pcu_op_t'(pwdata[3:0]);
					s_d.fsm = PCU_EXEC;
				end
				`PCU_OFF_ARG0:    s_d.arg0 = pwdata;
				`PCU_OFF_ARG1:    s_d.arg1 = pwdata;
				`PCU_OFF_ARG2:    s_d.arg2 = pwdata;
				`PCU_OFF_PSTATUS: begin
					s_d.umode = pwdata[`PCU_PSTAT_MODE];
					s_d.interrupt_priority_level  = pwdata[`PCU_PSTAT_INTERRUPT_PRIORITY_LEVEL +: 4];
				end
				`PCU_OFF_EVT_CLR: busy_wr = 1'b1;
				`PCU_OFF_EVT_EN:  s_d.evt_en = pwdata[3:0];
				default: ;
			endcase
		end

		// call sequencer
		case (s_q.fsm)
			PCU_IDLE: ;
			PCU_EXEC: begin
				s_d.fsm = PCU_IDLE;
				ev_set[`PCU_EVT_DONE] = 1'b1;
				if (s_q.umode) begin
					ev_set[`PCU_EVT_ILLEGAL] = 1'b1;
				end else begin
					case (s_q.op)
						PCU_OP_SWPIRQL: begin
							s_d.result = {28'h0, s_q.interrupt_priority_level};
							s_d.interrupt_priority_level   = s_q.arg0[3:0];
						end
						PCU_OP_SWPKSP: begin
							s_d.result = s_q.initial_kernel_stack_ptr;
							s_d.initial_kernel_stack_ptr   = s_q.arg0;
						end
						PCU_OP_SWPFW: begin
							s_d.fw_base = s_q.arg0;
							s_d.fw_jump = 1'b1;
							ev_set[`PCU_EVT_FWJUMP] = 1'b1;
						end
						PCU_OP_SWPSPACE: begin
							s_d.pdb  = s_q.arg0 << `PCU_PAGE_SHIFT;
							s_d.asid = s_q.arg1[7:0];
							if (s_q.arg2 != `PCU_RST_WORD) begin
								s_d.inval.valid = 1'b1;
								s_d.inval.kind  = PCU_INV_NONGLOBAL;
							end
						end
						PCU_OP_INVALL: begin
							s_d.inval.valid = 1'b1;
							s_d.inval.kind  = PCU_INV_ALL;
						end
						PCU_OP_INVMULT, PCU_OP_INVMULTID: begin
							s_d.idx       = `PCU_RST_WORD;
							s_d.walk_asid = (s_q.op == PCU_OP_INVMULT) ? s_q.asid : s_q.arg2[7:0];
							s_d.fsm       = (s_q.arg1 == `PCU_RST_WORD) ? PCU_IDLE : PCU_WREQ;
							ev_set[`PCU_EVT_DONE] = (s_q.arg1 == `PCU_RST_WORD);
						end
						PCU_OP_INVONE, PCU_OP_INVONEID: begin
							s_d.inval.valid      = 1'b1;
							s_d.inval.kind       = PCU_INV_VA;
							s_d.inval.va         = s_q.arg0;
							s_d.inval.match_asid = (s_q.op == PCU_OP_INVONEID);
							s_d.inval.asid       = s_q.arg1[7:0];
						end
						PCU_OP_WRENTRY: begin
							if (s_q.arg1 < `PCU_NUM_CLASSES) begin
								s_d.vec[s_q.arg1[2:0]] = s_q.arg0;
							end else begin
								ev_set[`PCU_EVT_PANIC] = 1'b1;
							end
						end
						PCU_OP_WRERRSUM: begin
							s_d.result = {26'h0, s_q.machine_check_error_summary};
							s_d.machine_check_error_summary[`PCU_MACHINE_CHECK_ERROR_SUMMARY_DPC +: 3] = s_q.arg0[5:3];
							mc_clr = {3'h0, s_q.arg0[2:0]};
						end
						default: ev_set[`PCU_EVT_ILLEGAL] = 1'b1;
					endcase
				end
			end
			PCU_WREQ: begin
				s_d.rd.req  = 1'b1;
				s_d.rd.addr = s_q.arg0 + {s_q.idx[29:0], 2'h0};
				s_d.fsm     = PCU_WWAIT;
			end
			PCU_WWAIT: begin
				s_d.rd.req = 1'b0;
				if (rd_valid) begin
					s_d.inval.valid      = 1'b1;
					s_d.inval.kind       = PCU_INV_VA;
					s_d.inval.va         = rd_data;
					s_d.inval.match_asid = 1'b1;
					s_d.inval.asid       = s_q.walk_asid;
					s_d.idx              = s_q.idx + 32'h1;
					if (s_q.idx + 32'h1 == s_q.arg1) begin
						s_d.fsm = PCU_IDLE;
						ev_set[`PCU_EVT_DONE] = 1'b1;
					end else begin
						s_d.fsm = PCU_WREQ;
					end
				end
			end
			default: s_d.fsm = PCU_IDLE;
		endcase
		// a call that starts the walk signals done only once, when the walk ends
		if (s_q.fsm == PCU_EXEC && !s_q.umode
			&& (s_q.op == PCU_OP_INVMULT || s_q.op == PCU_OP_INVMULTID) && s_q.arg1 != `PCU_RST_WORD) begin
			ev_set[`PCU_EVT_DONE] = 1'b0;
		end

		// machine check flags: hardware set wins over software clear
		// bit 0 check in progress, bit 1 system correctable, bit 2 processor correctable
		mc_set = {3'h0, proc_corr_evt, sys_corr_evt, mc_check_evt};
		s_d.machine_check_error_summary[2:0] = (s_q.machine_check_error_summary[2:0] & ~mc_clr[2:0]) | mc_set[2:0];

		// sticky events: set wins over clear
		s_d.evt = (s_q.evt & ~(busy_wr ? pwdata[3:0] : 4'h0)) | ev_set;
		s_d.irq = |(s_d.evt & s_d.evt_en);
	end

	// ==========================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q       <= '0;
			s_q.fsm   <= PCU_IDLE;
			s_q.umode <= `PCU_RST_UMODE;
			s_q.interrupt_priority_level  <= `PCU_RST_INTERRUPT_PRIORITY_LEVEL;
		end else begin
			s_q <= s_d;
		end
	end

	assign pready           = s_q.pready;
	assign prdata           = s_q.prdata;
	assign pslverr          = s_q.pslverr;
	assign irq_line_enable  = s_q.irq_mask;
	assign irq_line_pending = s_q.irq_pend;
	assign rd               = s_q.rd;
	assign inval            = s_q.inval;
	assign fw_jump          = s_q.fw_jump;
	assign fw_base          = s_q.fw_base;
	assign irq              = s_q.irq;

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire exec_priv = s_q.fsm == PCU_EXEC && !s_q.umode;

	a_user_illegal: assert property (s_q.fsm == PCU_EXEC && s_q.umode |=> s_q.evt[`PCU_EVT_ILLEGAL])
		else $error("user mode call did not raise illegal");
	a_user_no_effect: assert property (s_q.fsm == PCU_EXEC && s_q.umode |=>
		!s_q.inval.valid && !s_q.fw_jump && $stable(s_q.vec) && $stable(s_q.initial_kernel_stack_ptr) && $stable(s_q.pdb))
		else $error("user mode call changed state");
	a_interrupt_priority_level_swap: assert property (exec_priv && s_q.op == PCU_OP_SWPIRQL |=>
		s_q.result == {28'h0, $past(s_q.interrupt_priority_level)} && s_q.interrupt_priority_level == $past(s_q.arg0[3:0]))
		else $error("priority swap wrong");
	a_irq_mask: assert property ($changed(s_q.interrupt_priority_level) |-> ##1 s_q.irq_mask == level_mask($past(s_q.interrupt_priority_level)))
		else $error("enable mask does not follow level");
	a_ksp_swap: assert property (exec_priv && s_q.op == PCU_OP_SWPKSP |=>
		s_q.result == $past(s_q.initial_kernel_stack_ptr) && s_q.initial_kernel_stack_ptr == $past(s_q.arg0))
		else $error("stack swap wrong");
	a_fw_jump: assert property (exec_priv && s_q.op == PCU_OP_SWPFW |=> fw_jump && fw_base == $past(s_q.arg0))
		else $error("firmware jump missing");
	a_space_swap: assert property (exec_priv && s_q.op == PCU_OP_SWPSPACE |=>
		s_q.pdb == $past(s_q.arg0) << `PCU_PAGE_SHIFT && s_q.asid == $past(s_q.arg1[7:0]))
		else $error("space swap wrong");
	a_wrap_flush: assert property (exec_priv && s_q.op == PCU_OP_SWPSPACE |=>
		inval.valid == ($past(s_q.arg2) != 32'h0) && (!inval.valid || inval.kind == PCU_INV_NONGLOBAL))
		else $error("wrap flush wrong");
	a_inval_all: assert property (exec_priv && s_q.op == PCU_OP_INVALL |=> inval.valid && inval.kind == PCU_INV_ALL)
		else $error("invalidate all missing");
	a_walk_read: assert property (s_q.fsm == PCU_WREQ |=> rd.req ##1 !rd.req)
		else $error("walk read not issued");
	a_walk_inval: assert property (s_q.fsm == PCU_WWAIT && rd_valid |=>
		inval.valid && inval.match_asid && inval.asid == $past(s_q.walk_asid))
		else $error("walk invalidate wrong");
	a_one_inval: assert property (exec_priv && s_q.op == PCU_OP_INVONEID |=>
		inval.valid && inval.match_asid && inval.va == $past(s_q.arg0))
		else $error("single invalidate wrong");
	a_entry_store: assert property (exec_priv && s_q.op == PCU_OP_WRENTRY && s_q.arg1 < 32'h5 |=>
		s_q.vec[$past(s_q.arg1[2:0])] == $past(s_q.arg0))
		else $error("vector not stored");
	a_entry_panic: assert property (exec_priv && s_q.op == PCU_OP_WRENTRY && s_q.arg1 >= 32'h5 |=>
		s_q.evt[`PCU_EVT_PANIC] && $stable(s_q.vec))
		else $error("bad class not refused");
	a_errsum: assert property (exec_priv && s_q.op == PCU_OP_WRERRSUM |=>
		s_q.result == {26'h0, $past(s_q.machine_check_error_summary)} && s_q.machine_check_error_summary[5:3] == $past(s_q.arg0[5:3]))
		else $error("error summary write wrong");
	a_errsum_clr: assert property (exec_priv && s_q.op == PCU_OP_WRERRSUM && s_q.arg0[0] && !mc_check_evt
		|=> !s_q.machine_check_error_summary[`PCU_MACHINE_CHECK_ERROR_SUMMARY_MCK])
		else $error("check flag not cleared");

	c_swap_interrupt_priority_level: cover property (exec_priv && s_q.op == PCU_OP_SWPIRQL);
	c_walk_two: cover property (s_q.fsm == PCU_WWAIT ##[1:20] s_q.fsm == PCU_WREQ);
	c_user_call: cover property (s_q.fsm == PCU_EXEC && s_q.umode);
	c_irq_out: cover property (irq);
endmodule // pcu_top

// >>> tb/tb_privileged_call_unit.sv
// self-checking testbench of the privileged call unit
`timescale 1ns/10ps
`include "pcu_consts.svh"

module tb_privileged_call_unit;
	import pcu_pkg::*;

	// ==========================================================
	// signals
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr, asid_m;
	logic [31:0] pwdata, prdata, rd_data, fw_base, q, d, id_v, old, pdb_m;
	logic [15:0] irq_lines, irq_line_enable;
	logic        irq_line_pending, mc_check_evt, sys_corr_evt, proc_corr_evt, rd_valid, fw_jump, irq;
	logic [3:0]  lvl;
	logic [5:0]  sum_m;
	logic [31:0] vec_m [5];
	pcu_rd_t     rd;
	pcu_inval_t  inval;
	pcu_inval_t  invq [$];
	int          n_fail, n_checks, fwn, seed, i, k;

	pcu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.irq_lines(irq_lines), .irq_line_enable(irq_line_enable), .irq_line_pending(irq_line_pending),
		.mc_check_evt(mc_check_evt), .sys_corr_evt(sys_corr_evt), .proc_corr_evt(proc_corr_evt),
		.rd(rd), .rd_valid(rd_valid), .rd_data(rd_data), .inval(inval), .fw_jump(fw_jump),
		.fw_base(fw_base), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ==========================================================
	// monitors and array memory: answers one cycle after each read request
	always @(posedge pclk) begin
		if (inval.valid === 1'b1) begin
			invq.push_back(inval);
		end
		if (fw_jump === 1'b1) begin
			fwn++;
		end
		rd_valid <= rd.req;
		rd_data  <= (rd.req === 1'b1) ? va_of(rd.addr) : $random(seed);
	end

	// ==========================================================
	// helpers
	function automatic logic [31:0] va_of(input logic [31:0] a);
		return a ^ 32'h5A5A_0000;
	endfunction

	function automatic logic [15:0] en_of(input logic [3:0] l);
		return 16'hFFFE << l;
	endfunction

	task automatic test_done;
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// one apb transfer, entered right after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= dv;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(1'b1, 1'b0);
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		apb(1'b1, a, dv);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, x);
	endtask

	// runs one call and compares the event status once it is done
	task automatic call(input logic [3:0] op, input logic [31:0] p0, input logic [31:0] p1,
		input logic [31:0] p2, input logic [3:0] ev);
		int n;
		wr(`PCU_OFF_EVT_CLR, 32'h0000_000F);
		wr(`PCU_OFF_ARG0, p0);
		wr(`PCU_OFF_ARG1, p1);
		wr(`PCU_OFF_ARG2, p2);
		invq.delete();
		fwn = 0;
		wr(`PCU_OFF_CMD, {28'h0, op});
		if ((op == 4'h6 || op == 4'h7) && p1 > 1) begin
			wr(`PCU_OFF_CMD, 32'h0000_0005);
			chk(e, 1'b1);
		end
		n = 0;
		do begin
			apb(1'b0, `PCU_OFF_EVT_ST, 32'h0000_0000);
			n++;
		end while (q[`PCU_EVT_DONE] !== 1'b1 && n < 60);
		if (n >= 60) begin
			chk(1'b1, 1'b0);
			test_done();
		end
		chk(q, {28'h0, ev});
	endtask

	task automatic invc(input int x, input pcu_inv_kind_t kd, input logic m, input logic [7:0] a,
		input logic [31:0] v);
		chk(invq[x].kind, kd);
		if (kd == PCU_INV_VA) begin
			chk(invq[x].match_asid, m);
			chk(invq[x].va, v);
		end
		if (m) begin
			chk(invq[x].asid, a);
		end
	endtask

	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'heb098ffb;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{mc_check_evt, sys_corr_evt, proc_corr_evt} = '0;
		irq_lines = 16'h0000;
		presetn   = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_chk(`PCU_OFF_PSTATUS, `PCU_RST_WORD);
		rd_chk(`PCU_OFF_INITIAL_KERNEL_STACK_PTR, `PCU_RST_WORD);
		rd_chk(`PCU_OFF_MACHINE_CHECK_ERROR_SUMMARY, `PCU_RST_WORD);
		apb(1'b0, 8'hF0, 32'h0000_0000);
		chk({e, q}, {1'b1, 32'h0000_0000});
		wr(`PCU_OFF_EVT_EN, 32'h0000_000F);
		lvl = 4'h0;
		for (i = 0; i < 6; i++) begin
			d = (i == 0) ? 32'hF : (i == 1) ? 32'h0 : {28'h0, 4'($random(seed))};
			irq_lines <= 16'($random(seed));
			call(4'h1, d, 32'h0, 32'h0, 4'h4);
			rd_chk(`PCU_OFF_RESULT, {28'h0, lvl});
			rd_chk(`PCU_OFF_PSTATUS, {20'h0, d[3:0], 8'h00});
			chk(irq_line_enable, en_of(d[3:0]));
			chk(irq_line_pending, |(irq_lines & en_of(d[3:0])));
			lvl = d[3:0];
		end
		old = 32'h0000_0000;
		repeat (3) begin
			d = $random(seed);
			call(4'h2, d, 32'h0, 32'h0, 4'h4);
			rd_chk(`PCU_OFF_RESULT, old);
			rd_chk(`PCU_OFF_INITIAL_KERNEL_STACK_PTR, d);
			old = d;
		end
		wr(`PCU_OFF_INITIAL_KERNEL_STACK_PTR, ~old);
		rd_chk(`PCU_OFF_INITIAL_KERNEL_STACK_PTR, old);
		d = $random(seed);
		call(4'h3, d, $random(seed), $random(seed), 4'hC);
		chk(fwn, 1);
		chk(fw_base, d);
		for (i = 0; i < 2; i++) begin
			pdb_m = $random(seed);
			id_v  = $random(seed);
			call(4'h4, pdb_m, id_v, (i == 1) ? 32'h8000_0000 : 32'h0, 4'h4);
			rd_chk(`PCU_OFF_PDB, pdb_m << `PCU_PAGE_SHIFT);
			rd_chk(`PCU_OFF_ASID, {24'h0, id_v[7:0]});
			chk(invq.size(), i);
			if (i == 1) begin
				invc(0, PCU_INV_NONGLOBAL, 1'b0, 8'h00, 32'h0);
			end
		end
		pdb_m  = pdb_m << `PCU_PAGE_SHIFT;
		asid_m = id_v[7:0];
		call(4'h5, 32'h0, 32'h0, 32'h0, 4'h4);
		chk(invq.size(), 1);
		invc(0, PCU_INV_ALL, 1'b0, 8'h00, 32'h0);
		d    = $random(seed);
		id_v = $random(seed);
		call(4'h8, d, id_v, 32'h0, 4'h4);
		chk(invq.size(), 1);
		invc(0, PCU_INV_VA, 1'b0, 8'h00, d);
		call(4'h9, d, id_v, 32'h0, 4'h4);
		chk(invq.size(), 1);
		invc(0, PCU_INV_VA, 1'b1, id_v[7:0], d);
		d = {$random(seed)} & 32'hFFFF_FFF0;
		call(4'h6, d, 32'h3, 32'h0, 4'h4);
		chk(invq.size(), 3);
		for (k = 0; k < 3; k++) begin
			invc(k, PCU_INV_VA, 1'b1, asid_m, va_of(d + 32'(4 * k)));
		end
		call(4'h7, d, 32'h0, id_v, 4'h4);
		chk(invq.size(), 0);
		call(4'h7, d, 32'h2, id_v, 4'h4);
		chk(invq.size(), 2);
		for (k = 0; k < 2; k++) begin
			invc(k, PCU_INV_VA, 1'b1, id_v[7:0], va_of(d + 32'(4 * k)));
		end
		for (k = 0; k < 5; k++) begin
			vec_m[k] = $random(seed);
			call(4'hA, vec_m[k], 32'(k), 32'h0, 4'h4);
		end
		call(4'hA, $random(seed), 32'h5, 32'h0, 4'h6);
		for (k = 0; k < 5; k++) begin
			rd_chk(`PCU_OFF_VEC0 + 8'(4 * k), vec_m[k]);
		end
		sum_m = 6'h00;
		for (i = 0; i < 3; i++) begin
			d = (i == 0) ? 32'h2A : {26'h0, 6'($random(seed))};
			k = $random(seed);
			{proc_corr_evt, sys_corr_evt, mc_check_evt} <= 3'(k);
			@(posedge pclk);
			{proc_corr_evt, sys_corr_evt, mc_check_evt} <= 3'h0;
			sum_m[2:0] = sum_m[2:0] | 3'(k);
			call(4'hB, d, 32'h0, 32'h0, 4'h4);
			rd_chk(`PCU_OFF_RESULT, {26'h0, sum_m});
			sum_m = {d[5:3], sum_m[2:0] & ~d[2:0]};
			rd_chk(`PCU_OFF_MACHINE_CHECK_ERROR_SUMMARY, {26'h0, sum_m});
		end
		wr(`PCU_OFF_PSTATUS, {20'h0, lvl, 8'h01});
		for (k = 1; k < 12; k++) begin
			call(4'(k), $random(seed), 32'h1, 32'h1, 4'h5);
			chk(invq.size() + fwn, 0);
		end
		rd_chk(`PCU_OFF_INITIAL_KERNEL_STACK_PTR, old);
		rd_chk(`PCU_OFF_PDB, pdb_m);
		rd_chk(`PCU_OFF_ASID, {24'h0, asid_m});
		rd_chk(`PCU_OFF_MACHINE_CHECK_ERROR_SUMMARY, {26'h0, sum_m});
		rd_chk(`PCU_OFF_VEC0, vec_m[0]);
		rd_chk(`PCU_OFF_PSTATUS, {20'h0, lvl, 8'h01});
		wr(`PCU_OFF_PSTATUS, {20'h0, lvl, 8'h00});
		call(4'hC, 32'h0, 32'h0, 32'h0, 4'h5);
		@(posedge pclk);
		chk(irq, 1'b1);
		wr(`PCU_OFF_EVT_EN, 32'h0000_0000);
		@(posedge pclk);
		chk(irq, 1'b0);
		wr(`PCU_OFF_EVT_EN, 32'h0000_000F);
		@(posedge pclk);
		chk(irq, 1'b1);
		wr(`PCU_OFF_EVT_CLR, 32'h0000_000F);
		@(posedge pclk);
		chk(irq, 1'b0);
		rd_chk(`PCU_OFF_EVT_CLR, 32'h0000_0000);
		rd_chk(`PCU_OFF_EVT_ST, 32'h0000_0000);
		test_done();
	end

endmodule // tb_privileged_call_unit
